// file: hdl/csior_pkg.sv
// Package with offsets, field positions and reset values of the IO bank.
`default_nettype none
package csior_pkg;

  localparam logic [7:0] CSIOR_OFS_FLAGS  = 8'h00;
  localparam logic [7:0] CSIOR_OFS_SP     = 8'h02;
  localparam logic [7:0] CSIOR_OFS_CLKMD  = 8'h03;
  localparam logic [7:0] CSIOR_OFS_INTEN  = 8'h04;
  localparam logic [7:0] CSIOR_OFS_INTREQ = 8'h05;

  // Status flag bit positions.
  localparam int CSIOR_FLG_OV = 3;
  localparam int CSIOR_FLG_AC = 2;
  localparam int CSIOR_FLG_C  = 1;
  localparam int CSIOR_FLG_Z  = 0;

  // Clock mode field positions.
  localparam int CSIOR_CM_SEL_HI = 7;
  localparam int CSIOR_CM_SEL_LO = 5;
  localparam int CSIOR_CM_FAST   = 4;
  localparam int CSIOR_CM_TYPE   = 3;
  localparam int CSIOR_CM_SLOW   = 2;
  localparam int CSIOR_CM_WDT    = 1;
  localparam int CSIOR_CM_RSTPIN = 0;

  localparam logic [3:0] CSIOR_RST_FLAGS  = 4'h0;
  localparam logic [7:0] CSIOR_RST_SP     = 8'h00;
  localparam logic [7:0] CSIOR_RST_CLKMD  = 8'hF6;
  localparam logic [7:0] CSIOR_RST_INTEN  = 8'h00;
  localparam logic [7:0] CSIOR_RST_INTREQ = 8'h00;

  // Each saved return address takes two stack bytes.
  localparam logic [7:0] CSIOR_SP_STEP = 8'h02;

  typedef enum logic [2:0] {
    CSIOR_SRC_FAST = 3'b001,
    CSIOR_SRC_SLOW = 3'b010,
    CSIOR_SRC_EXT  = 3'b100
  } csior_src_t;

endpackage
`default_nettype wire

// file: hdl/csior_core_regs.sv
// Core system IO register bank: flags, stack pointer, clock mode, irq.
//
// Summary of operation
// R01: Overflow flag bit 3 set on signed overflow.
// R02: Nibble carry bit 2 on low-nibble carry/borrow.
// R03: Carry bit 1 on carry, borrow, shifts.
// R04: Zero bit 0 follows zero result.
// R05: Software leaves flag bits 7:4 unused.
// R06: Stack pointer readable, writable, resets to zero.
// R07: Software keeps stack pointer bit 0 clear.
// R08: Type 0 clock selection table, reset 111.
// R09: Type 1 clock selection table, 11x reserved.
// R10: Clock mode bit 3 picks table.
// R11: Clock mode bit 4 enables fast oscillator.
// R12: Bit 2 enables slow oscillator, gates watchdog.
// R13: Clock mode bit 1 enables watchdog.
// R14: Bit 0 chooses reset pin or IO.
// R15: Enable bits 7..2 gate internal sources.
// R16: Enable bits 1,0 gate pin groups.
// R17: Request flags set by events, software clears.
// R18: Interrupt presented while request and enable.
// R19: Software flag writes stored, later results overwrite.
`timescale 1ns/1ps
`default_nettype none
module csior_core_regs
  import csior_pkg::*;
#(
  parameter int N_IRQ = 8
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  input  wire logic [7:0]  i_alu_result,
  input  wire logic        i_alu_ov,
  input  wire logic        i_alu_ac,
  input  wire logic        i_alu_c,
  input  wire logic [3:0]  i_alu_flag_upd,
  input  wire logic        i_sp_push,
  input  wire logic        i_sp_pop,
  input  wire logic [7:0]  i_irq_event,
  output logic      [3:0]  o_flags,
  output logic      [7:0]  o_stack_pointer,
  output logic      [2:0]  o_sys_clk_src,
  output logic      [2:0]  o_sys_clk_div_log2,
  output logic             o_sys_clk_sel_valid,
  output logic             o_fast_osc_en,
  output logic             o_slow_osc_en,
  output logic             o_wdt_en,
  output logic             o_reset_pin_mode,
  output logic      [7:0]  o_irq_pending,
  output logic             o_irq
);

  if (N_IRQ != 8) begin : g_bad_n_irq
    $error("csior_core_regs serves exactly eight interrupt sources");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [3:0] flags_r,  flags_nxt;
  logic [7:0] sp_r,     sp_nxt;
  logic [7:0] clkmd_r,  clkmd_nxt;
  logic [7:0] inten_r,  inten_nxt;
  logic [7:0] intreq_r, intreq_nxt;
  logic [7:0] rdata_r,  rdata_nxt;
  logic       wr_flags;
  logic       wr_sp;
  logic       wr_clkmd;
  logic       wr_inten;
  logic       wr_intreq;
  logic       res_zero;

  assign wr_flags  = i_io_wr && (i_io_addr == CSIOR_OFS_FLAGS);
  assign wr_sp     = i_io_wr && (i_io_addr == CSIOR_OFS_SP);
  assign wr_clkmd  = i_io_wr && (i_io_addr == CSIOR_OFS_CLKMD);
  assign wr_inten  = i_io_wr && (i_io_addr == CSIOR_OFS_INTEN);
  assign wr_intreq = i_io_wr && (i_io_addr == CSIOR_OFS_INTREQ);
  assign res_zero  = (i_alu_result == 8'h00);

  always_comb begin
    // A software write is stored first; an ALU result in the same cycle
    // overwrites the flags it affects, so hardware status is never lost.
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = i_io_wdata[3:0]; // [R19]
    end
    if (i_alu_flag_upd[CSIOR_FLG_OV]) begin
      flags_nxt[CSIOR_FLG_OV] = i_alu_ov; // [R01]
    end
    if (i_alu_flag_upd[CSIOR_FLG_AC]) begin
      flags_nxt[CSIOR_FLG_AC] = i_alu_ac; // [R02]
    end
    if (i_alu_flag_upd[CSIOR_FLG_C]) begin
      flags_nxt[CSIOR_FLG_C] = i_alu_c; // [R03]
    end
    if (i_alu_flag_upd[CSIOR_FLG_Z]) begin
      flags_nxt[CSIOR_FLG_Z] = res_zero; // [R04]
    end

    // Stack pointer: IO write beats push/pop; odd values are the caller's
    // fault and are stored as written.
    sp_nxt = sp_r;
    if (wr_sp) begin
      sp_nxt = i_io_wdata; // [R06] [R07]
    end else if (i_sp_push && !i_sp_pop) begin
      sp_nxt = sp_r + CSIOR_SP_STEP;
    end else if (i_sp_pop && !i_sp_push) begin
      sp_nxt = sp_r - CSIOR_SP_STEP;
    end

    clkmd_nxt = wr_clkmd ? i_io_wdata : clkmd_r;
    inten_nxt = wr_inten ? i_io_wdata : inten_r; // [R15] [R16]

    // Events set requests; a set in the clearing cycle wins.
    intreq_nxt = (wr_intreq ? i_io_wdata : intreq_r) | i_irq_event; // [R17]

    rdata_nxt = rdata_r;
    if (i_io_rd) begin
      case (i_io_addr)
        CSIOR_OFS_FLAGS:  rdata_nxt = {4'h0, flags_r}; // [R05]
        CSIOR_OFS_SP:     rdata_nxt = sp_r; // [R06]
        CSIOR_OFS_CLKMD:  rdata_nxt = clkmd_r;
        CSIOR_OFS_INTEN:  rdata_nxt = inten_r;
        CSIOR_OFS_INTREQ: rdata_nxt = intreq_r;
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_r  <= CSIOR_RST_FLAGS;
      sp_r     <= CSIOR_RST_SP;
      clkmd_r  <= CSIOR_RST_CLKMD;
      inten_r  <= CSIOR_RST_INTEN;
      intreq_r <= CSIOR_RST_INTREQ;
      rdata_r  <= 8'h00;
    end else begin
      flags_r  <= flags_nxt;
      sp_r     <= sp_nxt;
      clkmd_r  <= clkmd_nxt;
      inten_r  <= inten_nxt;
      intreq_r <= intreq_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock mode decode.

  logic [2:0] clk_sel;
  logic [5:0] sel_code;
  assign clk_sel = clkmd_r[CSIOR_CM_SEL_HI:CSIOR_CM_SEL_LO];

  // Source and divider travel together as {source, log2 divide}.
  always_comb begin
    sel_code            = {CSIOR_SRC_SLOW, 3'h0};
    o_sys_clk_sel_valid = 1'b1;
    if (!clkmd_r[CSIOR_CM_TYPE]) begin // [R10]
      case (clk_sel) // [R08]
        3'h0:    sel_code = {CSIOR_SRC_FAST, 3'h2};
        3'h1:    sel_code = {CSIOR_SRC_FAST, 3'h1};
        3'h2:    sel_code = {CSIOR_SRC_FAST, 3'h0};
        3'h3:    sel_code = {CSIOR_SRC_EXT, 3'h2};
        3'h4:    sel_code = {CSIOR_SRC_EXT, 3'h1};
        3'h5:    sel_code = {CSIOR_SRC_EXT, 3'h0};
        3'h6:    sel_code = {CSIOR_SRC_SLOW, 3'h2};
        default: sel_code = {CSIOR_SRC_SLOW, 3'h0};
      endcase
    end else begin
      case (clk_sel) // [R09]
        3'h0:    sel_code = {CSIOR_SRC_FAST, 3'h4};
        3'h1:    sel_code = {CSIOR_SRC_FAST, 3'h3};
        3'h2:    sel_code = {CSIOR_SRC_SLOW, 3'h4};
        3'h3:    sel_code = {CSIOR_SRC_FAST, 3'h5};
        3'h4:    sel_code = {CSIOR_SRC_FAST, 3'h6};
        3'h5:    sel_code = {CSIOR_SRC_EXT, 3'h3};
        default: begin
          // Reserved codes: the clock generator keeps its present source.
          o_sys_clk_sel_valid = 1'b0;
        end
      endcase
    end
    o_sys_clk_src      = sel_code[5:3];
    o_sys_clk_div_log2 = sel_code[2:0];
  end

  assign o_fast_osc_en    = clkmd_r[CSIOR_CM_FAST]; // [R11]
  assign o_slow_osc_en    = clkmd_r[CSIOR_CM_SLOW]; // [R12]
  // The watchdog runs from the slow oscillator, so it stops with it.
  assign o_wdt_en         = clkmd_r[CSIOR_CM_WDT]
                            && clkmd_r[CSIOR_CM_SLOW]; // [R12] [R13]
  assign o_reset_pin_mode = clkmd_r[CSIOR_CM_RSTPIN]; // [R14]

  assign o_irq_pending   = intreq_r & inten_r; // [R18]
  assign o_irq           = |o_irq_pending;
  assign o_flags         = flags_r;
  assign o_stack_pointer = sp_r;
  assign o_io_rdata      = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  chk_zero_flag: assert property ( // [R04]
    i_alu_flag_upd[CSIOR_FLG_Z] |=> o_flags[CSIOR_FLG_Z] == $past(res_zero))
    else $error("zero flag does not follow result");

  chk_ov_flag: assert property ( // [R01]
    i_alu_flag_upd[CSIOR_FLG_OV] |=> o_flags[CSIOR_FLG_OV] == $past(i_alu_ov))
    else $error("overflow flag not updated");

  chk_carry_flags: assert property ( // [R03]
    i_alu_flag_upd[CSIOR_FLG_C] |=> o_flags[CSIOR_FLG_C] == $past(i_alu_c))
    else $error("carry flag not updated");

  chk_ac_flag: assert property ( // [R02]
    i_alu_flag_upd[CSIOR_FLG_AC] |=> o_flags[CSIOR_FLG_AC] == $past(i_alu_ac))
    else $error("nibble carry flag not updated");

  chk_flag_write: assert property ( // [R19]
    wr_flags && i_alu_flag_upd == 4'h0 |=> o_flags == $past(i_io_wdata[3:0]))
    else $error("software flag write not stored");

  chk_flag_readback: assert property ( // [R05]
    i_io_rd && i_io_addr == CSIOR_OFS_FLAGS |=> o_io_rdata[7:4] == 4'h0)
    else $error("reserved flag bits not zero");

  chk_sp_write_read: assert property ( // [R06]
    wr_sp |=> o_stack_pointer == $past(i_io_wdata))
    else $error("stack pointer write not stored");

  chk_sp_readback: assert property ( // [R06]
    i_io_rd && i_io_addr == CSIOR_OFS_SP |=> o_io_rdata == $past(sp_r))
    else $error("stack pointer readback wrong");

  chk_wdt_gate: assert property ( // [R12]
    !o_slow_osc_en |-> !o_wdt_en)
    else $error("watchdog runs without slow oscillator");

  chk_wdt_follow: assert property ( // [R13]
    wr_clkmd |=> o_wdt_en == ($past(i_io_wdata[1]) && $past(i_io_wdata[2])))
    else $error("watchdog enable does not follow write");

  chk_type_reserved: assert property ( // [R09]
    clkmd_r[CSIOR_CM_TYPE] && clk_sel[2:1] == 2'b11 |-> !o_sys_clk_sel_valid)
    else $error("reserved clock code flagged valid");

  chk_event_wins: assert property ( // [R17]
    i_irq_event[0] |=> intreq_r[0])
    else $error("interrupt event lost");

  chk_irq_clear: assert property ( // [R17] [R18]
    wr_intreq && i_io_wdata == 8'h00 && i_irq_event == 8'h00 |=> !o_irq)
    else $error("interrupt stays after requests cleared");

  chk_irq_raise: assert property ( // [R15] [R16]
    i_irq_event[7] && inten_r[7] && !wr_inten |=> o_irq_pending[7] && o_irq)
    else $error("enabled event not presented");

  cov_irq_taken: cover property (i_irq_event[2] ##1 o_irq);
  cov_clk_type1: cover property (
    wr_clkmd && i_io_wdata[3] ##1 o_sys_clk_sel_valid);
  cov_wdt_stop: cover property (wr_clkmd && !i_io_wdata[2] ##1 !o_wdt_en);
  cov_push_pop: cover property (i_sp_push ##1 i_sp_pop);

endmodule // csior_core_regs
`default_nettype wire

// file: tb/csior_core_model.sv
// Processor core model that issues IO register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module csior_core_model (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_io_rdata,
  output var  logic [7:0] o_io_addr,
  output var  logic       o_io_wr,
  output var  logic       o_io_rd,
  output var  logic [7:0] o_io_wdata
);
  initial begin
    o_io_addr  = 8'h00;
    o_io_wr    = 1'b0;
    o_io_rd    = 1'b0;
    o_io_wdata = 8'h00;
  end

  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_io_addr  <= a;
    o_io_wdata <= d;
    o_io_wr    <= 1'b1;
    @(posedge i_ref_clk);
    o_io_wr    <= 1'b0;
    // Stale data is inverted so a late capture cannot match by luck.
    o_io_wdata <= ~d;
  endtask

  task automatic io_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    o_io_addr <= a;
    o_io_rd   <= 1'b1;
    @(posedge i_ref_clk);
    o_io_rd   <= 1'b0;
    @(posedge i_ref_clk);
    #1 d = i_io_rdata;
  endtask
endmodule // csior_core_model
`default_nettype wire

// file: tb/csior_core_regs_test.sv
// Self-checking bench for the core system IO register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module csior_core_regs_test;
  import csior_pkg::*;
  logic       clk, nrst, wr, rd, ov, ac, c, push, pop;
  logic [7:0] addr, wdata, rdata, alu_res, irq_ev, d, sp, pend;
  logic [3:0] upd, flags;
  logic [2:0] src, dl2;
  logic       vld, fen, sen, wen, pmode, irq;
  logic [6:0] tbl [16];
  int         fail_count, n_tests, cyc, i;

  csior_core_regs dut (.i_ref_clk(clk), .i_nrst(nrst), .i_io_addr(addr),
    .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata),
    .i_alu_result(alu_res), .i_alu_ov(ov), .i_alu_ac(ac), .i_alu_c(c),
    .i_alu_flag_upd(upd), .i_sp_push(push), .i_sp_pop(pop),
    .i_irq_event(irq_ev), .o_flags(flags), .o_stack_pointer(sp),
    .o_sys_clk_src(src), .o_sys_clk_div_log2(dl2), .o_sys_clk_sel_valid(vld),
    .o_fast_osc_en(fen), .o_slow_osc_en(sen), .o_wdt_en(wen),
    .o_reset_pin_mode(pmode), .o_irq_pending(pend), .o_irq(irq));
  csior_core_model core (.i_ref_clk(clk), .i_io_rdata(rdata),
    .o_io_addr(addr), .o_io_wr(wr), .o_io_rd(rd), .o_io_wdata(wdata));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Ends every one-cycle strobe after the edge that takes it.
  task automatic tick;
    @(posedge clk);
    upd <= 4'h0;
    push <= 1'b0;
    pop <= 1'b0;
    irq_ev <= 8'h00;
    #1;
  endtask

  task automatic rchk(string nm, logic [7:0] a, logic [7:0] e);
    core.io_read(a, d);
    `CHK(nm, e, d)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk("flags", CSIOR_OFS_FLAGS, 8'h00);
    rchk("sp", CSIOR_OFS_SP, 8'h00);
    rchk("clkmd", CSIOR_OFS_CLKMD, 8'hF6);
    rchk("inten", CSIOR_OFS_INTEN, 8'h00);
    rchk("intreq", CSIOR_OFS_INTREQ, 8'h00);
    `CHK("osc rst", 4'hE, {fen, sen, wen, irq})
    rchk("unmapped", 8'h01, 8'h00);
    `CHK("src", 3'b010, src)
    `CHK("pin", 1'b0, pmode)
  endtask

  task automatic t_clock;
    tbl = '{7'h4A, 7'h49, 7'h48, 7'h62, 7'h61, 7'h60, 7'h52, 7'h50,
            7'h4C, 7'h4B, 7'h54, 7'h4D, 7'h4E, 7'h63, 7'h10, 7'h10};
    for (i = 0; i < 16; i++) begin
      core.io_write(CSIOR_OFS_CLKMD, {i[2:0], 1'b1, i[3], 3'b110});
      #1 `CHK("clksel", tbl[i], {vld, src, dl2})
    end
  endtask

  task automatic t_osc;
    core.io_write(CSIOR_OFS_CLKMD, 8'hE2);
    #1 `CHK("osc off", 3'b000, {fen, sen, wen})
    core.io_write(CSIOR_OFS_CLKMD, 8'hF7);
    #1 `CHK("osc on", 4'hF, {fen, sen, wen, pmode})
    core.io_write(CSIOR_OFS_CLKMD, 8'hF4);
    #1 `CHK("wdt off", 1'b0, wen)
  endtask

  task automatic t_flags;
    @(posedge clk);
    upd <= 4'h1;
    alu_res <= 8'h00;
    tick();
    `CHK("zero set", 4'h1, flags)
    @(posedge clk);
    upd <= 4'h1;
    alu_res <= 8'h5A;
    tick();
    `CHK("zero clr", 4'h0, flags)
    @(posedge clk);
    upd <= 4'hE;
    {ov, ac, c} <= 3'b111;
    tick();
    `CHK("ov ac c", 4'hE, flags)
    core.io_write(CSIOR_OFS_FLAGS, 8'h0B);
    rchk("flag wr", CSIOR_OFS_FLAGS, 8'h0B);
    @(posedge clk);
    upd <= 4'h2;
    c <= 1'b0;
    tick();
    `CHK("carry only", 4'h9, flags)
  endtask

  task automatic t_sp;
    core.io_write(CSIOR_OFS_SP, 8'h10);
    rchk("sp wr", CSIOR_OFS_SP, 8'h10);
    @(posedge clk);
    push <= 1'b1;
    tick();
    `CHK("push", 8'h12, sp)
    @(posedge clk);
    pop <= 1'b1;
    tick();
    @(posedge clk);
    pop <= 1'b1;
    tick();
    rchk("pop", CSIOR_OFS_SP, 8'h0E);
  endtask

  task automatic t_irq;
    for (i = 0; i < 8; i++) begin
      core.io_write(CSIOR_OFS_INTEN, 8'h01 << i);
      @(posedge clk);
      irq_ev <= 8'hFF;
      tick();
      `CHK("pending", 8'h01 << i, pend)
      rchk("request", CSIOR_OFS_INTREQ, 8'hFF);
      core.io_write(CSIOR_OFS_INTREQ, 8'h00);
      #1 `CHK("cleared", 1'b0, irq)
    end
    core.io_write(CSIOR_OFS_INTEN, 8'h00);
    @(posedge clk);
    irq_ev <= 8'h24;
    tick();
    `CHK("masked", 9'h000, {irq, pend})
    // A clear and an event in the same cycle: the event must survive.
    fork
      core.io_write(CSIOR_OFS_INTREQ, 8'h00);
      begin
        @(posedge clk);
        irq_ev <= 8'h04;
        tick();
      end
    join
    rchk("event wins", CSIOR_OFS_INTREQ, 8'h04);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    {ov, ac, c, push, pop} = 5'h00;
    {alu_res, irq_ev, upd} = 20'h00000;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_clock();
    t_osc();
    t_flags();
    t_sp();
    t_irq();
    // Reset in mid-run must bring every register back to its reset value.
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    print_verdict();
  end
endmodule // csior_core_regs_test
`default_nettype wire
